// file: hdl/regcopy_pkg.sv
// Shared constants and types for the table-driven register copier
package regcopy_pkg;

  // Table and database geometry
  localparam int ROWS       = 200;
  localparam int ROW_W      = 8;
  localparam int CNT_W      = 7;
  localparam int DB_AW      = 16;
  localparam int DB_DW      = 16;
  localparam int DELAY_W    = 16;
  localparam int PEND_W     = 8;
  localparam int FIFO_DEPTH = 8;

  // Copy length limits and area tops (tops are fixed, inclusive)
  localparam logic [CNT_W-1:0] MIN_COUNT  = 7'h01;
  localparam logic [CNT_W-1:0] MAX_COUNT  = 7'h64;
  localparam logic [DB_AW-1:0] USER_TOP   = 16'h0fff;
  localparam logic [DB_AW-1:0] STATUS_TOP = 16'h1fff;

  // Register byte offsets on the AHB-Lite port
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_ROW_SEL = 8'h04;
  localparam logic [7:0] OFS_SRC     = 8'h08;
  localparam logic [7:0] OFS_DEST    = 8'h0c;
  localparam logic [7:0] OFS_CFG     = 8'h10;
  localparam logic [7:0] OFS_DELAY   = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_COPIES  = 8'h1c;

  // Field positions
  localparam int CTRL_EN_BIT   = 0;
  localparam int CFG_SWAP_LSB  = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BAD_BIT  = 1;
  localparam int STAT_ROW_LSB  = 8;

  // AHB encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Reorderings of byte sequence 1234
  typedef enum logic [1:0] {
    SWAP_NONE      = 2'b00,  // 1234
    SWAP_WORD      = 2'b01,  // 3412
    SWAP_WORD_BYTE = 2'b10,  // 4321
    SWAP_BYTE      = 2'b11   // 2143
  } swap_t;

  // Engine states
  typedef enum logic [1:0] {
    ENG_IDLE = 2'b00,
    ENG_ROW  = 2'b01,
    ENG_COPY = 2'b10
  } eng_state_t;

endpackage

// file: hdl/stream_if.sv
// Valid/ready word stream between the copier and its FIFO
interface stream_if #(parameter int W = 16);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: hdl/table_driven_register_copier.sv
// Table-driven copy engine for the internal register database
// What this block does
// - Holds up to 200 independent copy rows, each on its own schedule.
// - A row copies exactly its count of consecutive registers, count 1 to 100.
// - Source start may be any register up to the top of the status area.
// - Destination always lies in the user data area; status area never written.
// - Per-row reordering: none, word swap, word and byte swap, byte swap.
// - A row runs only after its interval of processing scans has elapsed.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
module table_driven_register_copier
  import regcopy_pkg::*;
(
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Processing scan pulse
  input  wire logic              scan_tick,
  // Database read port, data one cycle after the strobe
  output logic                   db_rd_en,
  output logic      [DB_AW-1:0]  db_rd_addr,
  input  wire logic [DB_DW-1:0]  db_rd_data,
  // Database write port, held until accepted
  output logic                   db_wr_en,
  output logic      [DB_AW-1:0]  db_wr_addr,
  output logic      [DB_DW-1:0]  db_wr_data,
  input  wire logic              db_wr_ready
);

  // Row table
  logic [DB_AW-1:0]   src_mem   [ROWS];
  logic [DB_AW-1:0]   dest_mem  [ROWS];
  logic [CNT_W-1:0]   cnt_mem   [ROWS];
  logic [1:0]         swap_mem  [ROWS];
  logic [DELAY_W-1:0] delay_mem [ROWS];
  logic [DELAY_W-1:0] elapsed_r [ROWS];

  // Bus state
  logic               enable_r;
  logic [ROW_W-1:0]   row_sel_r;
  logic               wr_pend_r;
  logic               rd_pend_r;
  logic [7:0]         addr_r;
  logic               bad_row_r;
  logic [15:0]        copies_r;

  // Engine state
  eng_state_t         state_r;
  logic [PEND_W-1:0]  pend_r;
  logic [ROW_W-1:0]   row_r;
  logic [DB_AW-1:0]   src_r;
  logic [DB_AW-1:0]   dest_start_r;
  logic [CNT_W-1:0]   cnt_r;
  swap_t              swap_r;
  logic [CNT_W-1:0]   rd_idx_r;
  logic [CNT_W-1:0]   wr_idx_r;
  logic               rd_q_r;

  // Decoded per-cycle terms
  logic               addr_phase;
  logic               row_sel_ok;
  logic               row_due;
  logic               row_valid;
  logic               row_last;
  logic               issue;
  logic               wr_fire;
  logic               copy_done;
  logic               bad_set;
  logic               bad_clr;
  logic [DELAY_W-1:0] elapsed_nxt;

  stream_if #(.W(DB_DW)) push_if ();
  stream_if #(.W(DB_DW)) pop_if ();

  // Start plus span, kept one bit wider so overflow cannot wrap
  function automatic logic [DB_AW:0] span_end(input logic [DB_AW-1:0] start,
                                              input logic [CNT_W-1:0] cnt);
    span_end = {1'b0, start} + {{(DB_AW+1-CNT_W){1'b0}}, cnt} - 1'b1;
  endfunction

  // A row may run only with a legal count and both spans in range
  function automatic logic row_ok(input logic [DB_AW-1:0] src,
                                  input logic [DB_AW-1:0] dst,
                                  input logic [CNT_W-1:0] cnt);
    row_ok = (cnt >= MIN_COUNT) && (cnt <= MAX_COUNT)
          && (span_end(src, cnt) <= {1'b0, STATUS_TOP})
          && (span_end(dst, cnt) <= {1'b0, USER_TOP});
  endfunction

  // Source offset: word swaps read pairs crosswise, odd tail in place
  function automatic logic [CNT_W-1:0] src_off(input logic [CNT_W-1:0] i,
                                               input logic [CNT_W-1:0] cnt,
                                               input swap_t sw);
    logic pair_full;
    pair_full = ((i | 7'h01) < cnt);
    if ((sw == SWAP_WORD || sw == SWAP_WORD_BYTE) && pair_full)
      src_off = i ^ 7'h01;
    else
      src_off = i;
  endfunction

  // Byte exchange within one 16-bit register
  function automatic logic [DB_DW-1:0] byte_swap(input logic [DB_DW-1:0] d,
                                                 input swap_t sw);
    if (sw == SWAP_BYTE || sw == SWAP_WORD_BYTE)
      byte_swap = {d[7:0], d[15:8]};
    else
      byte_swap = d;
  endfunction

  // AHB address phase and register selection
  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign row_sel_ok = (row_sel_r < ROW_W'(ROWS));
  assign hresp      = HRESP_OKAY;
  // Reads take one wait state so a write just before is visible
  assign hreadyout  = !rd_pend_r;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r    <= '0;
    end
    else
    begin
      if (hreadyout)
      begin
        wr_pend_r <= addr_phase && hwrite;
        rd_pend_r <= addr_phase && !hwrite;
        if (addr_phase)
          addr_r <= haddr[7:0];
      end
      else
        rd_pend_r <= 1'b0;
    end
  end

  // Control and row select registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_r  <= 1'b0;
      row_sel_r <= '0;
    end
    else if (wr_pend_r)
    begin
      if (addr_r == OFS_CTRL)
        enable_r <= hwdata[CTRL_EN_BIT];
      if (addr_r == OFS_ROW_SEL)
        row_sel_r <= hwdata[ROW_W-1:0];
    end
  end

  // Row table writes; out-of-range selects are ignored
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int i = 0; i < ROWS; i++)
      begin
        src_mem[i]   <= '0;
        dest_mem[i]  <= '0;
        cnt_mem[i]   <= '0;
        swap_mem[i]  <= SWAP_NONE;
        delay_mem[i] <= '0;
      end
    end
    else if (wr_pend_r && row_sel_ok)
    begin
      case (addr_r)
        OFS_SRC:   src_mem[row_sel_r]   <= hwdata[DB_AW-1:0];
        OFS_DEST:  dest_mem[row_sel_r]  <= hwdata[DB_AW-1:0];
        OFS_DELAY: delay_mem[row_sel_r] <= hwdata[DELAY_W-1:0];
        OFS_CFG:
        begin
          cnt_mem[row_sel_r]  <= hwdata[CNT_W-1:0];
          swap_mem[row_sel_r] <= hwdata[CFG_SWAP_LSB+1:CFG_SWAP_LSB];
        end
        default: ;
      endcase
    end
  end

  // Read data registered in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= '0;
    else if (rd_pend_r)
    begin
      hrdata <= '0;
      case (addr_r)
        OFS_CTRL:    hrdata[CTRL_EN_BIT] <= enable_r;
        OFS_ROW_SEL: hrdata[ROW_W-1:0]   <= row_sel_r;
        OFS_SRC:     hrdata[DB_AW-1:0]   <= row_sel_ok ? src_mem[row_sel_r] : '0;
        OFS_DEST:    hrdata[DB_AW-1:0]   <= row_sel_ok ? dest_mem[row_sel_r] : '0;
        OFS_DELAY:   hrdata[DELAY_W-1:0] <= row_sel_ok ? delay_mem[row_sel_r] : '0;
        OFS_CFG:
        begin
          hrdata[CNT_W-1:0] <= row_sel_ok ? cnt_mem[row_sel_r] : '0;
          hrdata[CFG_SWAP_LSB+1:CFG_SWAP_LSB] <= row_sel_ok ? swap_mem[row_sel_r] : '0;
        end
        OFS_STATUS:
        begin
          hrdata[STAT_BUSY_BIT] <= (state_r != ENG_IDLE);
          hrdata[STAT_BAD_BIT]  <= bad_row_r;
          hrdata[STAT_ROW_LSB+ROW_W-1:STAT_ROW_LSB] <= row_r;
        end
        OFS_COPIES:  hrdata[15:0] <= copies_r;
        default:     ;
      endcase
    end
  end

  // Scans elapsed since a row's last run; zero interval behaves as one
  assign elapsed_nxt = (elapsed_r[row_r] == '1) ? elapsed_r[row_r]
                                                : elapsed_r[row_r] + 1'b1;
  assign row_due   = (elapsed_nxt >= delay_mem[row_r]);
  assign row_valid = row_ok(src_mem[row_r], dest_mem[row_r], cnt_mem[row_r]);
  assign row_last  = (row_r == ROW_W'(ROWS - 1));

  // Copy datapath handshakes
  assign issue     = (state_r == ENG_COPY) && (rd_idx_r < cnt_r) && !db_rd_en
                  && !rd_q_r && push_if.ready;
  assign wr_fire   = db_wr_en && db_wr_ready;
  assign copy_done = (state_r == ENG_COPY) && (wr_idx_r == cnt_r);

  // A due row with zero count is simply unused; other bad rows are flagged
  assign bad_set = (state_r == ENG_ROW) && row_due && !row_valid
                && (cnt_mem[row_r] != '0);
  assign bad_clr = wr_pend_r && (addr_r == OFS_STATUS) && hwdata[STAT_BAD_BIT];

  // Scan pulses queue up while a sweep is running; saturate, never wrap
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pend_r <= '0;
    else
    begin
      case ({scan_tick, (state_r == ENG_IDLE) && enable_r && (pend_r != '0)})
        2'b10:   pend_r <= (pend_r == '1) ? pend_r : pend_r + 1'b1;
        2'b01:   pend_r <= pend_r - 1'b1;
        default: pend_r <= pend_r;
      endcase
    end
  end

  // Sweep every row once per scan, running those whose interval is up
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r      <= ENG_IDLE;
      row_r        <= '0;
      src_r        <= '0;
      dest_start_r <= '0;
      cnt_r        <= '0;
      swap_r       <= SWAP_NONE;
      for (int i = 0; i < ROWS; i++)
        elapsed_r[i] <= '0;
    end
    else
    begin
      case (state_r)
        ENG_IDLE:
        begin
          if (enable_r && (pend_r != '0))
          begin
            row_r   <= '0;
            state_r <= ENG_ROW;
          end
        end
        ENG_ROW:
        begin
          if (row_due)
          begin
            elapsed_r[row_r] <= '0;
            if (row_valid)
            begin
              src_r        <= src_mem[row_r];
              dest_start_r <= dest_mem[row_r];
              cnt_r        <= cnt_mem[row_r];
              swap_r       <= swap_t'(swap_mem[row_r]);
              state_r      <= ENG_COPY;
            end
          end
          else
            elapsed_r[row_r] <= elapsed_nxt;
          if (!(row_due && row_valid))
          begin
            if (row_last)
              state_r <= ENG_IDLE;
            row_r <= row_last ? '0 : row_r + 1'b1;
          end
        end
        ENG_COPY:
        begin
          if (copy_done)
          begin
            state_r <= row_last ? ENG_IDLE : ENG_ROW;
            row_r   <= row_last ? '0 : row_r + 1'b1;
          end
        end
        default: state_r <= ENG_IDLE;
      endcase
    end
  end

  // Read side: one strobe at a time so FIFO room is known at issue
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      db_rd_en   <= 1'b0;
      db_rd_addr <= '0;
      rd_q_r     <= 1'b0;
      rd_idx_r   <= '0;
    end
    else
    begin
      db_rd_en <= issue;
      rd_q_r   <= db_rd_en;
      if (issue)
      begin
        db_rd_addr <= src_r + DB_AW'(src_off(rd_idx_r, cnt_r, swap_r));
        rd_idx_r   <= rd_idx_r + 1'b1;
      end
      else if (state_r != ENG_COPY)
        rd_idx_r <= '0;
    end
  end

  // Returned words enter the FIFO already byte-reordered
  assign push_if.valid = rd_q_r;
  assign push_if.data  = byte_swap(db_rd_data, swap_r);

  word_fifo #(
    .WIDTH (DB_DW),
    .DEPTH (FIFO_DEPTH)
  ) word_fifo_inst (
    .hclk    (hclk),
    .hresetn (hresetn),
    .wr      (push_if),
    .rd      (pop_if)
  );

  // Write side drains in order; the database may stall it
  assign db_wr_en     = pop_if.valid && (state_r == ENG_COPY);
  assign db_wr_addr   = dest_start_r + DB_AW'(wr_idx_r);
  assign db_wr_data   = pop_if.data;
  assign pop_if.ready = db_wr_ready && (state_r == ENG_COPY);

  // Destination index and completed-copy counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_idx_r <= '0;
      copies_r <= '0;
    end
    else
    begin
      if (wr_fire)
        wr_idx_r <= wr_idx_r + 1'b1;
      else if (state_r != ENG_COPY)
        wr_idx_r <= '0;
      if (copy_done)
        copies_r <= copies_r + 1'b1;
    end
  end

  // Sticky bad-row flag; a new bad row beats a clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bad_row_r <= 1'b0;
    else if (bad_set)
      bad_row_r <= 1'b1;
    else if (bad_clr)
      bad_row_r <= 1'b0;
  end

endmodule // table_driven_register_copier

// file: hdl/word_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Streams
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr_r;
  logic [PW-1:0]    rptr_r;
  logic [CW-1:0]    count_r;
  logic             push;
  logic             pop;

  // Honest full and empty flags
  assign wr.ready = (count_r != FULL_CNT);
  assign rd.valid = (count_r != '0);
  assign rd.data  = mem[rptr_r];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // Storage has no reset; only pointers matter
  always_ff @(posedge hclk)
  begin
    if (push)
      mem[wptr_r] <= wr.data;
  end

  // Pointers wrap at depth, which need not be a power of two
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wptr_r  <= '0;
      rptr_r  <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wptr_r <= (wptr_r == LAST_PTR) ? '0 : wptr_r + 1'b1;
      if (pop)
        rptr_r <= (rptr_r == LAST_PTR) ? '0 : rptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end

endmodule // word_fifo

// file: tb/table_driven_register_copier_assertions.sv
// Port-level checks for the table-driven register copier
module table_driven_register_copier_assertions
  import regcopy_pkg::*;
(
  // Clock and reset
  input wire logic             hclk,
  input wire logic             hresetn,
  // AHB-Lite
  input wire logic             hsel,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic             hreadyout,
  input wire logic             hresp,
  // Scan and database
  input wire logic             scan_tick,
  input wire logic             db_rd_en,
  input wire logic [DB_AW-1:0] db_rd_addr,
  input wire logic             db_wr_en,
  input wire logic [DB_AW-1:0] db_wr_addr,
  input wire logic [DB_DW-1:0] db_wr_data,
  input wire logic             db_wr_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Remembers a scan since reset; no copy may start before one
  logic seen_tick_r;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      seen_tick_r <= 1'b0;
    else if (scan_tick)
      seen_tick_r <= 1'b1;

  chk_rd_in_db: assert property (
    db_rd_en |-> db_rd_addr <= STATUS_TOP) else $error("read beyond status area");
  chk_wr_in_user: assert property (
    db_wr_en |-> db_wr_addr <= USER_TOP) else $error("write outside user area");
  chk_wr_hold: assert property (
    db_wr_en && !db_wr_ready |=> db_wr_en && $stable(db_wr_addr) && $stable(db_wr_data))
    else $error("write request dropped or changed");
  chk_rd_spacing: assert property (
    db_rd_en |=> !db_rd_en [*2]) else $error("reads closer than three cycles");
  chk_scan_first: assert property (
    db_rd_en |-> seen_tick_r) else $error("copy without any scan");
  chk_read_wait: assert property (
    hsel && hready && htrans == HTRANS_NONSEQ && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  chk_write_nowait: assert property (
    hsel && hready && htrans == HTRANS_NONSEQ && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  chk_resp_okay: assert property (
    hresp == HRESP_OKAY) else $error("response not okay");
endmodule // table_driven_register_copier_assertions

bind table_driven_register_copier table_driven_register_copier_assertions
  table_driven_register_copier_assertions_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .scan_tick(scan_tick),
  .db_rd_en(db_rd_en), .db_rd_addr(db_rd_addr), .db_wr_en(db_wr_en),
  .db_wr_addr(db_wr_addr), .db_wr_data(db_wr_data), .db_wr_ready(db_wr_ready));

// file: tb/table_driven_register_copier_tb.sv
// Self-checking bench for the table-driven register copier
module table_driven_register_copier_tb
  import regcopy_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             hclk, hresetn, hsel, hwrite, hready, scan_tick;
  logic             db_wr_ready = 1'b0;
  logic [31:0]      haddr, hwdata, hrdata;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             hreadyout, hresp, db_rd_en, db_wr_en;
  logic [DB_AW-1:0] db_rd_addr, db_wr_addr;
  logic [DB_DW-1:0] db_rd_data = '0;
  logic [DB_DW-1:0] db_wr_data;
  logic [DB_DW-1:0] mem [0:STATUS_TOP];
  logic [31:0]      seed = 32'hd225f5fb;
  logic [31:0]      rnd = 32'hd225f5fb;
  logic [31:0]      exp_q [$];
  int               num_errors = 0;
  int               tests_run = 0;
  int               runs = 0;
  // Row table: rows 5 and 6 are out of range, row 7 unused
  int    r_src [8] = '{16'h0010, 16'h0020, 16'h1ffb, 16'h0040, 16'h0100, 16'h0050,
                       16'h0060, 16'h0070};
  int    r_dst [8] = '{16'h0200, 16'h0300, 16'h0400, 16'h0500, 16'h0f9c, 16'h0600,
                       16'h0fff, 16'h0700};
  int    r_cnt [8] = '{1, 5, 5, 4, 100, 101, 2, 0};
  // Intervals distinct per row, kept small so six scans reach every row but unused row 7
  int    r_dly [8] = '{1, 3, 4, 5, 6, 0, 2, 7};
  int    r_el  [8] = '{default: 0};
  swap_t r_swp [8] = '{SWAP_NONE, SWAP_WORD, SWAP_WORD_BYTE, SWAP_BYTE, SWAP_NONE,
                       SWAP_NONE, SWAP_NONE, SWAP_WORD};

  assign hready = hreadyout;

  table_driven_register_copier table_driven_register_copier_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .scan_tick(scan_tick), .db_rd_en(db_rd_en),
    .db_rd_addr(db_rd_addr), .db_rd_data(db_rd_data), .db_wr_en(db_wr_en),
    .db_wr_addr(db_wr_addr), .db_wr_data(db_wr_data), .db_wr_ready(db_wr_ready));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction

  // 25 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  // Database model; stale read data inverted so it never looks valid
  always @(posedge hclk)
  begin
    rnd <= lfsr(rnd);
    db_wr_ready <= rnd[0] | rnd[1];
    db_rd_data <= db_rd_en ? mem[db_rd_addr] : ~db_rd_data;
  end

  // Accepted writes against the oldest note
  always @(posedge hclk)
    if (hresetn && db_wr_en && db_wr_ready)
    begin
      if (exp_q.size() == 0)
      begin
        num_errors++;
        $display("ERROR at %0t: got %h expected %h", $time, {db_wr_addr, db_wr_data}, 32'h0);
      end
      else
        check({db_wr_addr, db_wr_data}, exp_q.pop_front());
    end

  // Hang guard
  initial
  begin
    repeat (30000) @(posedge hclk);
    num_errors++;
    give_verdict();
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One AHB single transfer; hready and hrdata are taken at the rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    check(x, e);
  endtask

  task automatic set_row(input int r);
    wr(OFS_ROW_SEL, 32'(r));
    wr(OFS_SRC, 32'(r_src[r]));
    wr(OFS_DEST, 32'(r_dst[r]));
    wr(OFS_CFG, {22'h0, r_swp[r], 1'b0, 7'(r_cnt[r])});
    wr(OFS_DELAY, 32'(r_dly[r]));
  endtask

  // Notes the writes of n scans, then pulses them back to back
  task automatic scans(input int n);
    int idx;
    logic [15:0] w;
    for (int s = 0; s < n; s++)
      for (int r = 0; r < 8; r++)
        if (r_cnt[r] != 0 && ++r_el[r] >= r_dly[r])
        begin
          r_el[r] = 0;
          if (r_cnt[r] <= 100 && r_src[r] + r_cnt[r] - 1 <= STATUS_TOP
              && r_dst[r] + r_cnt[r] - 1 <= USER_TOP)
          begin
            runs++;
            for (int k = 0; k < r_cnt[r]; k++)
            begin
              idx = ((r_swp[r] inside {SWAP_WORD, SWAP_WORD_BYTE}) && (k ^ 1) < r_cnt[r])
                    ? (k ^ 1) : k;
              w = mem[r_src[r] + idx];
              if (r_swp[r] inside {SWAP_BYTE, SWAP_WORD_BYTE})
                w = {w[7:0], w[15:8]};
              exp_q.push_back({16'(r_dst[r] + k), w});
            end
          end
        end
    scan_tick <= 1'b1;
    repeat (n) @(posedge hclk);
    scan_tick <= 1'b0;
  endtask

  // Waits for all noted writes and for the sweep to finish
  task automatic drain();
    logic [31:0] x;
    while (exp_q.size() != 0) @(posedge hclk);
    do ahb(1'b0, OFS_STATUS, 32'h0, x); while (x[STAT_BUSY_BIT] !== 1'b0);
    check(x & 32'h3, 32'h2);
  endtask

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {hsel, hwrite, scan_tick} = 3'h0;
    {haddr, hwdata, htrans} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    for (int i = 0; i <= STATUS_TOP; i++)
    begin
      seed = lfsr(seed);
      mem[i] = seed[15:0];
    end
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(OFS_CTRL, 32'h0);
    rd_chk(OFS_STATUS, 32'h0);
    rd_chk(OFS_COPIES, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0);
    // Last row stores, one past it is refused
    wr(OFS_ROW_SEL, 32'd199);
    wr(OFS_SRC, 32'h1234);
    rd_chk(OFS_SRC, 32'h1234);
    wr(OFS_SRC, 32'h0);
    wr(OFS_ROW_SEL, 32'd200);
    wr(OFS_SRC, 32'h55);
    rd_chk(OFS_SRC, 32'h0);
    for (int r = 0; r < 8; r++) set_row(r);
    rd_chk(OFS_CFG, 32'h100);
    wr(OFS_CTRL, 32'h1);
    scans(1);
    drain();
    wr(OFS_STATUS, 32'h2);
    rd_chk(OFS_STATUS, 32'h0);
    // Queued scans while a sweep runs, with differing intervals
    scans(5);
    drain();
    rd_chk(OFS_COPIES, 32'(runs));
    // Disabled engine holds a scan pending and runs no sweep; any write is flagged by the monitor
    wr(OFS_CTRL, 32'h0);
    scan_tick <= 1'b1;
    @(posedge hclk);
    scan_tick <= 1'b0;
    repeat (300) @(posedge hclk);
    rd_chk(OFS_COPIES, 32'(runs));
    give_verdict();
  end
endmodule // table_driven_register_copier_tb
